// >>> hdl/pel_pkg.sv
// Function
// - On failure flash the first eight LEDs eight times quickly, then show upper code byte.
// - After upper byte, flash eight times again, then show lower code byte.
// - Only the first eight status LEDs carry the pattern on larger units.
// - Byte splits into LEDs 1-4 and 5-8, weights 8,4,2,1 from lowest LED.
// - A one bit lights its LED, a zero bit leaves it dark.
// - First shown byte is high half, second is low half of one code.
// - Codes 2010, 2011 for diagnostic default faults, 2020 for pattern fault.
// - Codes 2030 status read, 1020 slow clock, 2040 watchdog failure.
// - Codes 2031 mains fail, 2033 positive rail fail, 2035 logic device fail.
// - Ethernet unit: 3010 reset timeout, 3040 bad data, 3050 no PHY.
// - Serial group reset timeout gives 41x0, group index 1 to C.
// - Serial group loopback timeout gives 42x0, group index in third digit.
// - Serial group invalid data gives 44x0, group index in third digit.
// - Codes 5010 memory address error, 5020 data bus, 5030 address high.
// - Codes 5040 address bus low, 5055 flash checksum mismatch.
package pel_pkg;

  // APB register offsets
  localparam logic [7:0] PEL_REG_FAIL_OFS   = 8'h00;
  localparam logic [7:0] PEL_REG_GROUP_OFS  = 8'h04;
  localparam logic [7:0] PEL_REG_STATUS_OFS = 8'h08;
  localparam logic [7:0] PEL_REG_CODE_OFS   = 8'h0C;
  localparam logic [7:0] PEL_REG_IRQ_ST_OFS = 8'h10;
  localparam logic [7:0] PEL_REG_IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] PEL_REG_IRQ_CL_OFS = 8'h18;

  // Failure kinds, written by software to the fail register
  localparam logic [4:0] PEL_F_CLK_SLOW   = 5'h01;
  localparam logic [4:0] PEL_F_DIAG_DEF   = 5'h02;
  localparam logic [4:0] PEL_F_EXP_DEF    = 5'h03;
  localparam logic [4:0] PEL_F_DIAG_PAT   = 5'h04;
  localparam logic [4:0] PEL_F_STAT_READ  = 5'h05;
  localparam logic [4:0] PEL_F_MAINS      = 5'h06;
  localparam logic [4:0] PEL_F_POS_RAIL   = 5'h07;
  localparam logic [4:0] PEL_F_LOGIC_DEV  = 5'h08;
  localparam logic [4:0] PEL_F_WATCHDOG   = 5'h09;
  localparam logic [4:0] PEL_F_ETH_RESET  = 5'h0A;
  localparam logic [4:0] PEL_F_ETH_DATA   = 5'h0B;
  localparam logic [4:0] PEL_F_ETH_NOPHY  = 5'h0C;
  localparam logic [4:0] PEL_F_SER_RESET  = 5'h0D;
  localparam logic [4:0] PEL_F_SER_LOOP   = 5'h0E;
  localparam logic [4:0] PEL_F_SER_DATA   = 5'h0F;
  localparam logic [4:0] PEL_F_MEM_ADDR   = 5'h10;
  localparam logic [4:0] PEL_F_MEM_DBUS   = 5'h11;
  localparam logic [4:0] PEL_F_MEM_AHIGH  = 5'h12;
  localparam logic [4:0] PEL_F_MEM_ALOW   = 5'h13;
  localparam logic [4:0] PEL_F_FLASH_SUM  = 5'h14;

  // Error codes
  localparam logic [15:0] PEL_C_CLK_SLOW  = 16'h1020;
  localparam logic [15:0] PEL_C_DIAG_DEF  = 16'h2010;
  localparam logic [15:0] PEL_C_EXP_DEF   = 16'h2011;
  localparam logic [15:0] PEL_C_DIAG_PAT  = 16'h2020;
  localparam logic [15:0] PEL_C_STAT_READ = 16'h2030;
  localparam logic [15:0] PEL_C_MAINS     = 16'h2031;
  localparam logic [15:0] PEL_C_POS_RAIL  = 16'h2033;
  localparam logic [15:0] PEL_C_LOGIC_DEV = 16'h2035;
  localparam logic [15:0] PEL_C_WATCHDOG  = 16'h2040;
  localparam logic [15:0] PEL_C_ETH_RESET = 16'h3010;
  localparam logic [15:0] PEL_C_ETH_DATA  = 16'h3040;
  localparam logic [15:0] PEL_C_ETH_NOPHY = 16'h3050;
  localparam logic [7:0]  PEL_C_SER_RESET = 8'h41;
  localparam logic [7:0]  PEL_C_SER_LOOP  = 8'h42;
  localparam logic [7:0]  PEL_C_SER_DATA  = 8'h44;
  localparam logic [15:0] PEL_C_MEM_ADDR  = 16'h5010;
  localparam logic [15:0] PEL_C_MEM_DBUS  = 16'h5020;
  localparam logic [15:0] PEL_C_MEM_AHIGH = 16'h5030;
  localparam logic [15:0] PEL_C_MEM_ALOW  = 16'h5040;
  localparam logic [15:0] PEL_C_FLASH_SUM = 16'h5055;
  localparam logic [15:0] PEL_C_NONE      = 16'h0000;

  localparam logic [3:0]  PEL_GROUP_MIN   = 4'h1;
  localparam logic [3:0]  PEL_GROUP_MAX   = 4'hC;
  localparam int          PEL_FLASH_COUNT = 8;

  // Timing, 40 MHz clock
  localparam int PEL_CLK_HZ       = 40_000_000;
  localparam int PEL_FLASH_HALF_MS = 50;
  localparam int PEL_HOLD_MS       = 3000;
  localparam int PEL_FLASH_HALF_CYC = PEL_CLK_HZ / 1000 * PEL_FLASH_HALF_MS;
  localparam int PEL_HOLD_CYC       = PEL_CLK_HZ / 1000 * PEL_HOLD_MS;

  localparam logic [31:0] PEL_RST_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    PEL_IDLE,
    PEL_FLASH_ON,
    PEL_FLASH_OFF,
    PEL_SHOW,
    PEL_DONE
  } pel_state_t;

endpackage

// >>> hdl/pel_code_map.sv
module pel_code_map
  import pel_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  kind_i,
  input  wire logic [3:0]  group_i,
  output logic      [15:0] code_o,
  output logic             valid_o
);

  logic [15:0] code_next;
  logic        valid_next;
  logic        grp_ok;

  assign grp_ok = (group_i >= PEL_GROUP_MIN) && (group_i <= PEL_GROUP_MAX);

  always_comb
  begin
    code_next  = PEL_C_NONE;
    valid_next = 1'b1;
    case (kind_i)
      PEL_F_CLK_SLOW:  code_next = PEL_C_CLK_SLOW;
      PEL_F_DIAG_DEF:  code_next = PEL_C_DIAG_DEF;
      PEL_F_EXP_DEF:   code_next = PEL_C_EXP_DEF;
      PEL_F_DIAG_PAT:  code_next = PEL_C_DIAG_PAT;
      PEL_F_STAT_READ: code_next = PEL_C_STAT_READ;
      PEL_F_MAINS:     code_next = PEL_C_MAINS;
      PEL_F_POS_RAIL:  code_next = PEL_C_POS_RAIL;
      PEL_F_LOGIC_DEV: code_next = PEL_C_LOGIC_DEV;
      PEL_F_WATCHDOG:  code_next = PEL_C_WATCHDOG;
      PEL_F_ETH_RESET: code_next = PEL_C_ETH_RESET;
      PEL_F_ETH_DATA:  code_next = PEL_C_ETH_DATA;
      PEL_F_ETH_NOPHY: code_next = PEL_C_ETH_NOPHY;
      PEL_F_SER_RESET:
      begin
        code_next  = {PEL_C_SER_RESET, group_i, 4'h0};
        valid_next = grp_ok;
      end
      PEL_F_SER_LOOP:
      begin
        code_next  = {PEL_C_SER_LOOP, group_i, 4'h0};
        valid_next = grp_ok;
      end
      PEL_F_SER_DATA:
      begin
        code_next  = {PEL_C_SER_DATA, group_i, 4'h0};
        valid_next = grp_ok;
      end
      PEL_F_MEM_ADDR:  code_next = PEL_C_MEM_ADDR;
      PEL_F_MEM_DBUS:  code_next = PEL_C_MEM_DBUS;
      PEL_F_MEM_AHIGH: code_next = PEL_C_MEM_AHIGH;
      PEL_F_MEM_ALOW:  code_next = PEL_C_MEM_ALOW;
      PEL_F_FLASH_SUM: code_next = PEL_C_FLASH_SUM;
      default:         valid_next = 1'b0;
    endcase
    if (!valid_next)
    begin
      code_next = PEL_C_NONE;
    end
  end

  // Registered so the code is stable a cycle after the kind is written
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      code_o  <= PEL_C_NONE;
      valid_o <= 1'b0;
    end
    else
    begin
      code_o  <= code_next;
      valid_o <= valid_next;
    end
  end

endmodule

// >>> hdl/pel_led_reporter.sv
module pel_led_reporter
  import pel_pkg::*;
#(
  parameter int LED_COUNT      = 48,
  parameter int FLASH_HALF_CYC = PEL_FLASH_HALF_CYC,
  parameter int HOLD_CYC       = PEL_HOLD_CYC
)
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [LED_COUNT-1:0] led_o,
  output logic                      irq_o
);

  localparam int CNT_W = $clog2(HOLD_CYC > FLASH_HALF_CYC ? HOLD_CYC + 1 : FLASH_HALF_CYC + 1);
  localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(HOLD_CYC - 1);

  pel_state_t       state_reg;
  logic [CNT_W-1:0] timer_reg;
  logic [2:0]       flash_reg;
  logic             byte_sel_reg;
  logic [4:0]       kind_reg;
  logic [3:0]       group_reg;
  logic             start_reg;
  logic             start_d_reg;
  logic [15:0]      shown_code_reg;
  logic [1:0]       irq_st_reg;
  logic [1:0]       irq_en_reg;
  logic [7:0]       pattern;
  logic [15:0]      map_code;
  logic             map_valid;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic             busy;
  logic             tick;
  logic             ev_start;
  logic             ev_done;
  logic [1:0]       irq_clr;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  // Pending start counts as busy so a quick second fail write is dropped
  assign busy    = start_reg || start_d_reg || ((state_reg != PEL_IDLE) && (state_reg != PEL_DONE));
  assign addr_ok = (paddr == PEL_REG_FAIL_OFS) || (paddr == PEL_REG_GROUP_OFS) ||
                   (paddr == PEL_REG_STATUS_OFS) || (paddr == PEL_REG_CODE_OFS) ||
                   (paddr == PEL_REG_IRQ_ST_OFS) || (paddr == PEL_REG_IRQ_EN_OFS) ||
                   (paddr == PEL_REG_IRQ_CL_OFS);
  assign pslverr = psel && penable && !addr_ok;

  pel_code_map u_map
  (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .kind_i  (kind_reg),
    .group_i (group_reg),
    .code_o  (map_code),
    .valid_o (map_valid)
  );

  // Software registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      kind_reg   <= 5'h00;
      group_reg  <= 4'h0;
      irq_en_reg <= 2'b00;
      start_reg  <= 1'b0;
    end
    else
    begin
      start_reg <= 1'b0;
      if (wr_en && (paddr == PEL_REG_FAIL_OFS) && !busy)
      begin
        kind_reg  <= pwdata[4:0];
        start_reg <= 1'b1;
      end
      if (wr_en && (paddr == PEL_REG_GROUP_OFS))
      begin
        group_reg <= pwdata[3:0];
      end
      if (wr_en && (paddr == PEL_REG_IRQ_EN_OFS))
      begin
        irq_en_reg <= pwdata[1:0];
      end
    end
  end

  // Start one cycle late so the mapped code has settled
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      start_d_reg <= 1'b0;
    end
    else
    begin
      start_d_reg <= start_reg;
    end
  end

  assign ev_start = start_d_reg && map_valid;
  assign tick     = (state_reg == PEL_SHOW) ? (timer_reg == HOLD_LAST) : (timer_reg == FLASH_LAST);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_reg      <= PEL_IDLE;
      timer_reg      <= '0;
      flash_reg      <= 3'd0;
      byte_sel_reg   <= 1'b0;
      shown_code_reg <= PEL_C_NONE;
    end
    else
    begin
      case (state_reg)
        PEL_IDLE, PEL_DONE:
        begin
          if (ev_start)
          begin
            shown_code_reg <= map_code;
            state_reg      <= PEL_FLASH_ON;
            timer_reg      <= '0;
            flash_reg      <= 3'd0;
            byte_sel_reg   <= 1'b0;
          end
        end
        PEL_FLASH_ON:
        begin
          timer_reg <= tick ? '0 : timer_reg + 1'b1;
          if (tick)
          begin
            state_reg <= PEL_FLASH_OFF;
          end
        end
        PEL_FLASH_OFF:
        begin
          timer_reg <= tick ? '0 : timer_reg + 1'b1;
          if (tick)
          begin
            flash_reg <= flash_reg + 3'd1;
            // Eight on/off pairs before the byte appears
            state_reg <= (flash_reg == 3'(PEL_FLASH_COUNT - 1)) ? PEL_SHOW : PEL_FLASH_ON;
          end
        end
        PEL_SHOW:
        begin
          timer_reg <= tick ? '0 : timer_reg + 1'b1;
          if (tick)
          begin
            byte_sel_reg <= 1'b1;
            state_reg    <= byte_sel_reg ? PEL_DONE : PEL_FLASH_ON;
          end
        end
        default:
        begin
          state_reg <= PEL_IDLE;
        end
      endcase
    end
  end

  assign ev_done = (state_reg == PEL_SHOW) && tick && byte_sel_reg;

  always_comb
  begin
    // High byte first, then low byte
    pattern = byte_sel_reg ? shown_code_reg[7:0] : shown_code_reg[15:8];
  end

  // LED 1 is bit 0 of led_o and carries weight 8 of the upper nibble
  genvar gi;
  generate
    for (gi = 0; gi < LED_COUNT; gi++)
    begin : g_led
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
        begin
          led_o[gi] <= 1'b0;
        end
        else if (gi >= 8)
        begin
          led_o[gi] <= 1'b0;
        end
        else if (state_reg == PEL_FLASH_ON)
        begin
          led_o[gi] <= 1'b1;
        end
        else if (state_reg == PEL_SHOW)
        begin
          led_o[gi] <= pattern[7 - (gi % 8)];
        end
        else
        begin
          led_o[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupts: bit0 report started, bit1 report finished; set wins over clear
  assign irq_clr = (wr_en && (paddr == PEL_REG_IRQ_CL_OFS)) ? pwdata[1:0] : 2'b00;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_st_reg <= 2'b00;
    end
    else
    begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | {ev_done, ev_start};
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(((irq_st_reg & ~irq_clr) | {ev_done, ev_start}) & irq_en_reg);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      prdata <= PEL_RST_ZERO;
    end
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        PEL_REG_FAIL_OFS:   prdata <= {27'h0, kind_reg};
        PEL_REG_GROUP_OFS:  prdata <= {28'h0, group_reg};
        PEL_REG_STATUS_OFS: prdata <= {28'h0, byte_sel_reg, flash_reg == 3'd0, busy, state_reg == PEL_DONE};
        PEL_REG_CODE_OFS:   prdata <= {16'h0, shown_code_reg};
        PEL_REG_IRQ_ST_OFS: prdata <= {30'h0, irq_st_reg};
        PEL_REG_IRQ_EN_OFS: prdata <= {30'h0, irq_en_reg};
        default:            prdata <= PEL_RST_ZERO;
      endcase
    end
  end

endmodule

// >>> sim/pel_led_reporter_properties.sv
module pel_led_reporter_checker
  import pel_pkg::*;
#(
  parameter int LED_COUNT      = 48,
  parameter int FLASH_HALF_CYC = 4,
  parameter int HOLD_CYC       = 20
)
(
  input wire logic                 mclk_i,
  input wire logic                 rst_i,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [LED_COUNT-1:0] led_o,
  input wire logic                 irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  prev_reg;
  logic [31:0] run_reg;
  logic [3:0]  flash_reg;
  logic        idx_reg;
  logic        chg;
  logic        byte_end;
  logic        byte_go;
  assign chg      = led_o[7:0] != prev_reg;
  assign byte_end = chg && prev_reg != 8'h00 && prev_reg != 8'hFF;
  assign byte_go  = chg && led_o[7:0] != 8'h00 && led_o[7:0] != 8'hFF;
  // Run length of the pattern that just ended, seen at the change
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      prev_reg <= 8'h00;
      run_reg  <= 32'h0;
    end
    else
    begin
      prev_reg <= led_o[7:0];
      run_reg  <= chg ? 32'h1 : run_reg + 32'h1;
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      flash_reg <= 4'h0;
      idx_reg   <= 1'b0;
    end
    else
    begin
      if (chg && led_o[7:0] == 8'hFF)
        flash_reg <= flash_reg + 4'h1;
      else if (byte_go)
        flash_reg <= 4'h0;
      if (byte_end)
        idx_reg <= ~idx_reg;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_flash_end;
    chg && flash_reg != 4'h0 && (prev_reg == 8'hFF || prev_reg == 8'h00);
  endsequence
  sequence s_byte_end;
    byte_end;
  endsequence
  a_flash_width: assert property (s_flash_end |-> run_reg == FLASH_HALF_CYC)
    else $error("flash half has wrong length");
  a_burst_count: assert property (byte_go |-> flash_reg == PEL_FLASH_COUNT)
    else $error("byte shown after wrong flash count");
  a_burst_limit: assert property (chg && led_o[7:0] == 8'hFF |-> flash_reg < 4'h8)
    else $error("too many flashes in a burst");
  a_byte_hold: assert property (s_byte_end |-> run_reg == HOLD_CYC)
    else $error("byte hold has wrong length");
  a_high_then_burst: assert property (s_byte_end and !idx_reg |-> led_o[7:0] == 8'hFF)
    else $error("no burst after high byte");
  a_low_then_dark: assert property (s_byte_end and idx_reg |-> (led_o[7:0] == 8'h00)[*3])
    else $error("leds not dark after low byte");
  a_upper_leds_dark: assert property (led_o[LED_COUNT-1:8] == '0)
    else $error("led above eighth lit");
  a_irq_masked: assert property (psel && penable && pwrite && paddr == PEL_REG_IRQ_EN_OFS &&
    pwdata[1:0] == 2'b00 |-> ##2 !irq_o)
    else $error("irq high while masked");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  a_unmapped_err: assert property (psel && penable && paddr > PEL_REG_IRQ_CL_OFS |-> pslverr)
    else $error("unmapped access without error");
endmodule

bind pel_led_reporter pel_led_reporter_checker #(
  .LED_COUNT(LED_COUNT), .FLASH_HALF_CYC(FLASH_HALF_CYC), .HOLD_CYC(HOLD_CYC)
) u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .led_o(led_o), .irq_o(irq_o)
);

// >>> sim/pel_led_observer.sv
module pel_led_observer
  import pel_pkg::*;
#(
  parameter int LED_COUNT = 48,
  parameter int READ_CYC  = 10
)
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic [LED_COUNT-1:0] led_i,
  output logic      [15:0]          code_o,
  output logic      [7:0]           nbyte_o,
  output logic      [3:0]           burst_o,
  output logic                      wide_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  prev_reg;
  logic [7:0]  rev;
  logic [31:0] run_reg;
  logic [3:0]  flash_reg;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      rev[i] = led_i[7 - i];  // LED1 is weight 8 of the high nibble, lit means one
  end
  // Patterns shorter than READ_CYC are too quick to read, so flashes never count as digits
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      prev_reg  <= 8'h00;
      run_reg   <= 32'h0;
      flash_reg <= 4'h0;
      code_o    <= 16'h0;
      nbyte_o   <= 8'h0;
      burst_o   <= 4'h0;
      wide_o    <= 1'b0;
    end
    else
    begin
      prev_reg <= led_i[7:0];
      run_reg  <= (led_i[7:0] != prev_reg) ? 32'h1 : run_reg + 32'h1;
      if (led_i[7:0] == 8'hFF && prev_reg != 8'hFF)
        flash_reg <= flash_reg + 4'h1;
      if (led_i[7:0] == prev_reg && run_reg == READ_CYC && led_i[7:0] != 8'h00 && led_i[7:0] != 8'hFF)
      begin
        code_o    <= {code_o[7:0], rev};  // First byte read ends up high
        nbyte_o   <= nbyte_o + 8'h1;
        burst_o   <= flash_reg;
        flash_reg <= 4'h0;
      end
      if (|led_i[LED_COUNT-1:8])
        wide_o <= 1'b1;
    end
  end
endmodule

// >>> sim/power_on_self_test_error_led_display_tb_top.sv
module power_on_self_test_error_led_display_tb_top
  import pel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_i;
  logic        rst_i   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_o;
  logic [47:0] led_o;
  logic [15:0] seen_code;
  logic [7:0]  seen_n;
  logic [3:0]  seen_burst;
  logic        seen_wide;
  logic [31:0] rd;
  logic        err;
  logic [31:0] en = 32'h0;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [15:0] exp_tab [1:20] = '{16'h1020, 16'h2010, 16'h2011, 16'h2020, 16'h2030, 16'h2031, 16'h2033,
    16'h2035, 16'h2040, 16'h3010, 16'h3040, 16'h3050, 16'h4100, 16'h4200, 16'h4400, 16'h5010, 16'h5020,
    16'h5030, 16'h5040, 16'h5055};
  logic [4:0]  rk [4] = '{5'h0D, 5'h0E, 5'h15, 5'h00};
  logic [3:0]  rg [4] = '{4'h0, 4'hD, 4'h1, 4'h1};

  pel_led_reporter #(.LED_COUNT(48), .FLASH_HALF_CYC(4), .HOLD_CYC(20)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .led_o(led_o), .irq_o(irq_o));
  pel_led_observer #(.LED_COUNT(48), .READ_CYC(10)) u_obs (
    .mclk_i(mclk_i), .rst_i(rst_i), .led_i(led_o), .code_o(seen_code), .nbyte_o(seen_n),
    .burst_o(seen_burst), .wide_o(seen_wide));

  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1)
      @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rep(input logic [4:0] k, input logic [3:0] g, input logic [15:0] exp);
    logic [7:0] n0;
    int i;
    n0 = seen_n;
    apb(1'b1, PEL_REG_IRQ_CL_OFS, 32'h3);
    apb(1'b1, PEL_REG_GROUP_OFS, {28'h0, g});
    apb(1'b1, PEL_REG_FAIL_OFS, {27'h0, k});
    apb(1'b1, PEL_REG_IRQ_EN_OFS, en);
    apb(1'b1, PEL_REG_FAIL_OFS, {27'h0, k ^ 5'h01});
    i = 0;
    rd = 32'h0;
    while (rd[1] !== 1'b1 && i < 400)
    begin
      apb(1'b0, PEL_REG_IRQ_ST_OFS, 32'h0);
      i++;
    end
    chk("report done", 32'h1, {31'h0, rd[1]});
    chk("code shown", {16'h0, exp}, {16'h0, seen_code});
    chk("bytes read", 32'h2, {24'h0, seen_n - n0});
    chk("last burst", 32'h8, {28'h0, seen_burst});
    apb(1'b0, PEL_REG_CODE_OFS, 32'h0);
    chk("code reg", {16'h0, exp}, rd);
    apb(1'b0, PEL_REG_FAIL_OFS, 32'h0);
    chk("kind kept", {27'h0, k}, rd);
    chk("irq level", {31'h0, en != 32'h0}, {31'h0, irq_o});
  endtask

  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk("leds at reset", 32'h0, {31'h0, |led_o});
    apb(1'b0, PEL_REG_STATUS_OFS, 32'h0);
    chk("status reset", 32'h4, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    rep(PEL_F_MAINS, 4'h1, 16'h2031);
    apb(1'b0, PEL_REG_IRQ_ST_OFS, 32'h0);
    chk("masked status", 32'h3, rd);
    en = 32'h3;
    apb(1'b1, PEL_REG_IRQ_EN_OFS, en);
    @(posedge mclk_i);
    chk("irq unmasked", 32'h1, {31'h0, irq_o});
    apb(1'b1, PEL_REG_IRQ_CL_OFS, 32'h3);
    @(posedge mclk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    for (int k = 1; k <= 20; k++)
    begin
      for (int g = 1; g <= ((k >= 13 && k <= 15) ? 12 : 1); g++)
      begin
        if (k >= 13 && k <= 15)
          rep(k[4:0], g[3:0], {exp_tab[k][15:8], g[3:0], 4'h0});
        else
          rep(k[4:0], g[3:0], exp_tab[k]);
      end
    end
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, PEL_REG_IRQ_CL_OFS, 32'h3);
      apb(1'b1, PEL_REG_GROUP_OFS, {28'h0, rg[r]});
      apb(1'b1, PEL_REG_FAIL_OFS, {27'h0, rk[r]});
      repeat (3) @(posedge mclk_i);
      chk("refused leds", 32'h0, {31'h0, |led_o});
      apb(1'b0, PEL_REG_IRQ_ST_OFS, 32'h0);
      chk("refused status", 32'h0, rd);
    end
    chk("upper leds", 32'h0, {31'h0, seen_wide});
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge mclk_i);
    bad_count++;
    test_done();
  end
endmodule
